// *** pkg/svrmc_pkg.sv ***
// svrmc_pkg: constants and carrier types of the supervisor reset and mode control block.
// assumes a single 250 MHz clock; every analog crossing arrives as a comparator flag.
package svrmc_pkg;

	// clock and internal oscillator timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_NS       = 33000;
	localparam int TICK_CYC_DEF  = (TICK_NS * 1000) / CLK_PERIOD_PS;

	// warning pulse: least time rounded up to whole oscillator ticks
	localparam int WARN_MIN_NS   = 200000;
	localparam int WARN_MAX_NS   = 500000;
	localparam int WARN_TICKS    = (WARN_MIN_NS + TICK_NS - 1) / TICK_NS;

	// reset hold time in oscillator ticks; plain default
	localparam int RST_HOLD_DEF  = 5;

	// consecutive low samples needed before the sense input counts as low
	localparam int SENSE_SAMPLES = 3;

	// below-ground pulses that arm the battery-disconnect seal
	localparam int SEAL_PULSES   = 3;

	// number of bits through the input synchroniser
	localparam int SYNC_W        = 6;

	// comparator flags from the analog front end
	typedef struct packed {
		logic supplyAboveBat;
		logic supplyAboveTrip;
		logic senseAboveTrip;
		logic senseBelowGround;
	} svrmc_cmp_t;

	// processor-facing and power-switch outputs
	typedef struct packed {
		logic rstOut;
		logic rstOut_n;
		logic warnInt_n;
		logic warnIntOe;
		logic supplyFailOut;
		logic supplyFailOut_n;
	} svrmc_proc_t;

	typedef enum logic [1:0] {
		W_IDLE,
		W_ACTIVE,
		W_DONE
	} svrmc_warn_t;

	typedef enum logic [1:0] {
		R_OFF,
		R_HOLD,
		R_DOWN
	} svrmc_rst_t;

endpackage

// *** rtl/svrmc_sync.sv ***
// svrmc_sync: two-flop synchroniser for a bundle of independent levels.
// assumes each bit is a slow level; bits are not coherent with one another.
module svrmc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         arst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule

// *** rtl/svrmc_ctrl.sv ***
// svrmc_ctrl: reset, early-warning, power-fail and seal sequencing of a supervisor.
// assumes comparator flags and mode pins are asynchronous levels; the strobe is active low.
// Operation
// (RULE_01) three below-ground pulses enter storage seal
// (RULE_02) supply off then above battery clears seal
// (RULE_03) fail outputs follow supply versus battery level
// (RULE_04) mode pin picks volatile or battery-backed behaviour
// (RULE_05) volatile mode isolates processor signals below battery
// (RULE_06) warning pulse lasts at least 200 us
// (RULE_07) volatile mode floats warning below battery level
// (RULE_08) volatile mode asserts reset below supply trip
// (RULE_09) volatile power-up holds reset for hold time
// (RULE_10) no warning until supply reaches trip level
// (RULE_11) warning ends by timeout or sense rising
// (RULE_12) power-up warning pulse between 0 and 500 us
// (RULE_13) backed mode stays silent after warning ends
// (RULE_14) backed mode sense rise restarts processor by reset
// (RULE_15) backed mode no reset on supply falling
// (RULE_16) backed mode pulses warning then holds high
// (RULE_17) backed power-up reset after battery level reached
// (RULE_18) sense low during reset swaps reset for warning
// (RULE_19) strobe while sense low gives another warning
// (RULE_20) three consecutive low samples raise the warning
// (RULE_21) crossings synchronised; times counted in oscillator ticks
module svrmc_ctrl
	import svrmc_pkg::*;
#(
	parameter int TICK_CYCLES    = TICK_CYC_DEF,
	parameter int RST_HOLD_TICKS = RST_HOLD_DEF
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// analog comparator flags and pins
	input  svrmc_pkg::svrmc_cmp_t cmpIn,
	input  wire logic             reset_mode_select,
	input  wire logic             watchdog_strobe_n,
	// processor and power-switch outputs
	output svrmc_pkg::svrmc_proc_t procOut,
	// battery seal and processor isolation
	output logic                  battConnect,
	output logic                  procIsolate
);
	import svrmc_pkg::*;

	if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk_tick
		$error("svrmc_ctrl: TICK_CYCLES out of range");
	end
	if (RST_HOLD_TICKS < 1 || RST_HOLD_TICKS > 255) begin : g_chk_rst
		$error("svrmc_ctrl: RST_HOLD_TICKS out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisation
	logic [SYNC_W-1:0] syncQ;
	logic              supAboveBat;
	logic              supAboveTrip;
	logic              senseHigh;
	logic              belowGnd;
	logic              modeBacked;
	logic              strobe_n;

	svrmc_sync #(
		.W (SYNC_W)
	) u_sync (
		.mclk   (mclk),
		.arst_n (arst_n),
		.d      ({cmpIn.supplyAboveBat, cmpIn.supplyAboveTrip, cmpIn.senseAboveTrip,
		          cmpIn.senseBelowGround, reset_mode_select, watchdog_strobe_n}),
		.q      (syncQ)
	); // RULE_21

	assign {supAboveBat, supAboveTrip, senseHigh, belowGnd, modeBacked, strobe_n} = syncQ;

	logic supAboveBatD_ff;
	logic belowGndD_ff;
	logic strobeD_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			supAboveBatD_ff <= 1'b0;
			belowGndD_ff    <= 1'b0;
			strobeD_ff      <= 1'b0;
		end else begin
			supAboveBatD_ff <= supAboveBat;
			belowGndD_ff    <= belowGnd;
			strobeD_ff      <= strobe_n;
		end
	end

	logic supRise;
	logic gndPulse;
	logic strobeFell;

	assign supRise    = supAboveBat && !supAboveBatD_ff;
	assign gndPulse   = belowGnd && !belowGndD_ff;
	assign strobeFell = !strobe_n && strobeD_ff;

	////////////////////////////////////////////////////////////////////////////////
	// internal oscillator tick
	logic [15:0] tickCnt_ff;
	logic        tick;

	assign tick = (tickCnt_ff == 16'(TICK_CYCLES - 1));

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_ff <= 16'h0000;
		end else if (tick) begin
			tickCnt_ff <= 16'h0000;
		end else begin
			tickCnt_ff <= tickCnt_ff + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sense filter: time-domain hysteresis against supply noise
	logic [1:0] senseCnt_ff;
	logic       senseLow;

	assign senseLow = (senseCnt_ff == 2'(SENSE_SAMPLES));

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			senseCnt_ff <= 2'h0;
		end else if (senseHigh) begin
			senseCnt_ff <= 2'h0; // RULE_20
		end else if (tick && !senseLow) begin
			senseCnt_ff <= senseCnt_ff + 2'h1; // RULE_20
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// battery-disconnect seal
	logic [1:0] sealCnt_ff;
	logic       sealed_ff;
	logic       offSeen_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sealCnt_ff <= 2'h0;
		end else if (!supAboveTrip || sealed_ff) begin
			sealCnt_ff <= 2'h0;
		end else if (gndPulse) begin
			sealCnt_ff <= sealCnt_ff + 2'h1; // RULE_01
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sealed_ff  <= 1'b0;
			offSeen_ff <= 1'b0;
		end else if (sealed_ff) begin
			if (!supAboveBat) begin
				offSeen_ff <= 1'b1;
			end else if (offSeen_ff) begin
				sealed_ff  <= 1'b0; // RULE_02
				offSeen_ff <= 1'b0;
			end
		end else if (supAboveTrip && gndPulse && sealCnt_ff == 2'(SEAL_PULSES - 1)) begin
			sealed_ff  <= 1'b1; // RULE_01
			offSeen_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// early-warning state machine
	svrmc_warn_t warnState_ff;
	svrmc_rst_t  rstState_ff;
	logic [7:0]  warnTmr_ff;
	logic [7:0]  rstTmr_ff;
	logic        dippedTrip_ff;
	logic        warnStart;
	logic        wdRestart;
	logic        swapToWarn;

	// a strobe retests the supply only in battery-backed mode
	assign swapToWarn = modeBacked && rstState_ff == R_HOLD && senseLow; // RULE_18
	assign warnStart  = supAboveTrip && senseLow && (warnState_ff == W_IDLE || swapToWarn
		|| (modeBacked && strobeFell && warnState_ff == W_DONE)); // RULE_10 RULE_19
	assign wdRestart  = modeBacked && warnState_ff == W_DONE && senseHigh && supAboveBat
		&& !dippedTrip_ff; // RULE_14

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			warnState_ff <= W_IDLE;
			warnTmr_ff   <= 8'h00;
		end else begin
			case (warnState_ff)
				W_IDLE: begin
					if (warnStart) begin
						warnState_ff <= W_ACTIVE;
						warnTmr_ff   <= 8'h00;
					end
				end
				W_ACTIVE: begin
					if (senseHigh) begin
						warnState_ff <= W_IDLE; // RULE_11
					end else if (tick) begin
						// ending on the extra tick edge keeps the pulse above its least time
						if (warnTmr_ff == 8'(WARN_TICKS)) begin
							warnState_ff <= W_DONE; // RULE_06 RULE_12 RULE_16
						end else begin
							warnTmr_ff <= warnTmr_ff + 8'h01;
						end
					end
				end
				W_DONE: begin
					if (senseHigh || !supAboveBat) begin
						warnState_ff <= W_IDLE; // RULE_13
					end else if (warnStart) begin
						warnState_ff <= W_ACTIVE; // RULE_19
						warnTmr_ff   <= 8'h00;
					end
				end
				default: begin
					warnState_ff <= W_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dippedTrip_ff <= 1'b0;
		end else if (warnState_ff != W_DONE) begin
			dippedTrip_ff <= 1'b0;
		end else if (!supAboveTrip) begin
			dippedTrip_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset state machine
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rstState_ff <= R_OFF;
			rstTmr_ff   <= 8'h00;
		end else if (!modeBacked && !supAboveTrip) begin
			rstState_ff <= R_DOWN; // RULE_04 RULE_08
		end else if (modeBacked && !supAboveBat) begin
			rstState_ff <= R_OFF; // RULE_15 RULE_17
		end else if (modeBacked && (supRise || wdRestart)) begin
			rstState_ff <= R_HOLD; // RULE_14 RULE_17
			rstTmr_ff   <= 8'h00;
		end else begin
			case (rstState_ff)
				R_DOWN: begin
					rstState_ff <= R_HOLD; // RULE_09
					rstTmr_ff   <= 8'h00;
				end
				R_HOLD: begin
					if (swapToWarn) begin
						rstState_ff <= R_OFF; // RULE_18
					end else if (tick) begin
						if (rstTmr_ff == 8'(RST_HOLD_TICKS - 1)) begin
							rstState_ff <= R_OFF; // RULE_09 RULE_17
						end else begin
							rstTmr_ff <= rstTmr_ff + 8'h01;
						end
					end
				end
				default: begin
					rstState_ff <= R_OFF;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	logic        isolate;
	svrmc_proc_t proc_ff;

	assign isolate = !modeBacked && !supAboveBat;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			proc_ff <= '{rstOut: 1'b1, rstOut_n: 1'b0, warnInt_n: 1'b1, warnIntOe: 1'b0,
				supplyFailOut: 1'b1, supplyFailOut_n: 1'b0};
		end else begin
			proc_ff.supplyFailOut   <= !supAboveBat; // RULE_03
			proc_ff.supplyFailOut_n <= supAboveBat; // RULE_03
			proc_ff.warnInt_n       <= !(warnState_ff == W_ACTIVE) || isolate; // RULE_16
			proc_ff.warnIntOe       <= !isolate; // RULE_07
			// below the battery a backed processor sees no reset, whatever the state says
			proc_ff.rstOut          <= (rstState_ff != R_OFF) && supAboveBat && !isolate; // RULE_05
			proc_ff.rstOut_n        <= (rstState_ff == R_OFF || !supAboveBat) && !isolate; // RULE_15
		end
	end

	logic sealOut_ff;
	logic isoOut_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sealOut_ff <= 1'b1;
			isoOut_ff  <= 1'b1;
		end else begin
			sealOut_ff <= !sealed_ff;
			isoOut_ff  <= isolate; // RULE_05
		end
	end

	assign procOut     = proc_ff;
	assign battConnect = sealOut_ff;
	assign procIsolate = isoOut_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_fail_follow;
		$fell(supAboveBat) |=> procOut.supplyFailOut && !procOut.supplyFailOut_n;
	endproperty
	a_fail_follow: assert property (p_fail_follow) else $error("fail outputs lag"); // RULE_03
	property p_float_low;
		!modeBacked && !supAboveBat |=> !procOut.warnIntOe && !procOut.rstOut;
	endproperty
	a_float_low: assert property (p_float_low) else $error("not isolated"); // RULE_07
	property p_vol_rst;
		!modeBacked && !supAboveTrip && supAboveBat |=> ##1 procOut.rstOut && !procOut.rstOut_n;
	endproperty
	a_vol_rst: assert property (p_vol_rst) else $error("reset missing"); // RULE_08
	property p_backed_norst;
		modeBacked && !supAboveBat |=> ##1 !procOut.rstOut && procOut.rstOut_n;
	endproperty
	a_backed_norst: assert property (p_backed_norst) else $error("reset in backed mode"); // RULE_15
	// the filter may only become low on an oscillator tick after a low sample
	property p_filter;
		senseLow |-> !$past(senseHigh) && ($past(senseLow) || $past(tick));
	endproperty
	a_filter: assert property (p_filter) else $error("filter wrong"); // RULE_20
	property p_release;
		warnState_ff == W_ACTIVE && senseHigh |=> warnState_ff == W_IDLE;
	endproperty
	a_release: assert property (p_release) else $error("warning not released"); // RULE_11
	property p_arm;
		warnState_ff == W_IDLE && !supAboveTrip |=> warnState_ff == W_IDLE;
	endproperty
	a_arm: assert property (p_arm) else $error("warning before trip level"); // RULE_10
	property p_swap;
		modeBacked && rstState_ff == R_HOLD && senseLow && supAboveTrip && supAboveBat
			|=> rstState_ff == R_OFF && warnState_ff == W_ACTIVE;
	endproperty
	a_swap: assert property (p_swap) else $error("reset not swapped"); // RULE_18
	property p_seal_set;
		$rose(sealed_ff) |-> $past(supAboveTrip) && $past(sealCnt_ff) == 2'h2;
	endproperty
	a_seal_set: assert property (p_seal_set) else $error("seal set wrongly"); // RULE_01
	property p_seal_clr;
		sealed_ff && offSeen_ff && supAboveBat |=> !sealed_ff ##2 battConnect;
	endproperty
	a_seal_clr: assert property (p_seal_clr) else $error("seal not cleared"); // RULE_02
	property p_min_pulse;
		warnState_ff == W_ACTIVE && warnTmr_ff < 8'(WARN_TICKS) && !senseHigh
			|=> warnState_ff == W_ACTIVE;
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("warning too short"); // RULE_06

	c_warn_done: cover property (warnState_ff == W_ACTIVE ##1 warnState_ff == W_DONE);
	c_swap: cover property (swapToWarn);
	c_seal: cover property ($rose(sealed_ff));
	c_wd_restart: cover property (wdRestart);

endmodule

// *** tb/svrmc_proc_model.sv ***
// svrmc_proc_model: processor side of the supervisor, strobe and seal pulses.
// assumes the bench clock; pins change just after a rising edge.
module svrmc_proc_model (
	// clock
	input  wire logic mclk,
	// pins toward the supervisor
	output logic      strobe_n,
	output logic      belowGnd
);
	initial begin
		strobe_n = 1'b1;
		belowGnd = 1'b0;
	end

	////////////////////////////////////////
	// low for several cycles so the synchroniser sees the falling edge
	task automatic strobe();
		@(posedge mclk) #1 strobe_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1 strobe_n = 1'b1;
	endtask

	// seal pulses are only honoured under good supply
	task automatic seal(input int n);
		repeat (n) begin
			@(posedge mclk) #1 belowGnd = 1'b1;
			repeat (4) @(posedge mclk);
			#1 belowGnd = 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask
endmodule

// *** tb/svrmc_ctrl_tb.sv ***
// svrmc_ctrl_tb: self-checking bench of the supervisor sequencing block.
// assumes short oscillator ticks; comparator flags are driven as clean levels.
module svrmc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import svrmc_pkg::*;

	localparam int T = 8;
	localparam int H = 5;
	localparam int S_FAIL = 1, S_OE = 2, S_WARN = 3, S_RSTN = 4, S_RST = 5, S_BATT = 6;
	localparam int S_ISO = 7;
	localparam int SLO = 2 * T, SHI = 4 * T + 6;
	localparam int WLO = WARN_TICKS * T - 2, WHI = (WARN_TICKS + 1) * T + 4;
	localparam int HLO = (H - 1) * T, HHI = (H + 1) * T + 8;

	logic        mclk;
	logic        arst_n;
	logic        bat, trip, sense, mode;
	logic        strobe_n, belowGnd;
	logic        battConnect, procIsolate;
	svrmc_cmp_t  cmpIn;
	svrmc_proc_t procOut;
	logic [7:0]  obs;
	int          failCount;
	int          checkCount;

	// a seal pulse drags the sense comparator low as well
	assign cmpIn = svrmc_cmp_t'({bat, trip, sense & ~belowGnd, belowGnd});
	assign obs = {procIsolate, battConnect, procOut};

	initial mclk = 1'b0;
	always #2 mclk = ~mclk;

	svrmc_ctrl #(
		.TICK_CYCLES    (T),
		.RST_HOLD_TICKS (H)
	) i_svrmc_ctrl (
		.mclk              (mclk),
		.arst_n            (arst_n),
		.cmpIn             (cmpIn),
		.reset_mode_select (mode),
		.watchdog_strobe_n (strobe_n),
		.procOut           (procOut),
		.battConnect       (battConnect),
		.procIsolate       (procIsolate)
	);

	svrmc_proc_model i_svrmc_proc_model (.mclk(mclk), .strobe_n(strobe_n), .belowGnd(belowGnd));

	////////////////////////////////////////
	task automatic stopTest();
		if (failCount == 0 && checkCount > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	function automatic logic inr(input int n, input int lo, input int hi);
		return n >= lo && n <= hi;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// cycles until an output takes a level, -1 when it never does
	task automatic waitFor(input int sel, input logic v, input int maxc, output int n);
		n = 0;
		while (obs[sel] !== v && n <= maxc) begin
			cyc(1);
			n++;
		end
		if (n > maxc)
			n = -1;
	endtask

	task automatic pulse(output int s, output int w);
		waitFor(S_WARN, 1'b0, 5 * T, s);
		waitFor(S_WARN, 1'b1, WHI, w);
	endtask

	task automatic doReset(input logic m);
		arst_n = 1'b0;
		{bat, trip, sense} = 3'h0;
		mode = m;
		cyc(16);
		check("reset values", obs, 8'hea);
		arst_n = 1'b1;
		cyc(4);
	endtask

	////////////////////////////////////////
	task automatic tVolUp();
		int n, s, w;
		doReset(1'b0);
		bat = 1'b1;
		waitFor(S_FAIL, 1'b0, 6, n);
		check("fail fall", inr(n, 0, 6), 1'b1);
		check("fail_n", obs[0], 1'b1);
		waitFor(S_WARN, 1'b0, 6 * T, n);
		check("warn below trip", n, -1);
		check("iso off", obs[S_ISO], 1'b0);
		check("oe on", obs[S_OE], 1'b1);
		trip = 1'b1;
		fork
			waitFor(S_RST, 1'b0, HHI, n);
			pulse(s, w);
		join
		check("rst hold", inr(n, HLO, HHI), 1'b1);
		check("rst_n end", obs[S_RSTN], 1'b1);
		check("up warn start", inr(s, 0, SHI), 1'b1);
		check("up warn width", inr(w, WLO, WHI), 1'b1);
	endtask

	task automatic tFilter();
		int n, s;
		sense = 1'b1;
		cyc(8);
		sense = 1'b0;
		cyc(2 * T - 2);
		sense = 1'b1;
		waitFor(S_WARN, 1'b0, 5 * T, n);
		check("short dip", n, -1);
		sense = 1'b0;
		waitFor(S_WARN, 1'b0, 5 * T, s);
		check("dip start", inr(s, SLO, SHI), 1'b1);
		cyc(T);
		sense = 1'b1;
		waitFor(S_WARN, 1'b1, 6, n);
		check("sense ends warn", inr(n, 0, 6), 1'b1);
	endtask

	task automatic tVolDown();
		int n, s, w;
		sense = 1'b0;
		pulse(s, w);
		check("down start", inr(s, SLO, SHI), 1'b1);
		check("down width", inr(w, WLO, WHI), 1'b1);
		check("rst above trip", obs[S_RST], 1'b0);
		trip = 1'b0;
		waitFor(S_RST, 1'b1, 6, n);
		check("rst at trip", inr(n, 0, 6), 1'b1);
		cyc(4 * T);
		check("rst_n kept", obs[S_RSTN], 1'b0);
		bat = 1'b0;
		waitFor(S_ISO, 1'b1, 6, n);
		check("isolate", inr(n, 0, 6), 1'b1);
		check("warn float", obs[S_OE], 1'b0);
		check("rst grounded", obs[S_RST:S_RSTN], 2'h0);
		check("fail high", obs[S_FAIL:0], 2'h2);
	endtask

	task automatic tSeal();
		int n;
		doReset(1'b0);
		{bat, sense} = 2'h3;
		cyc(2);
		trip = 1'b1;
		waitFor(S_WARN, 1'b0, HHI, n);
		check("no up pulse", n, -1);
		i_svrmc_proc_model.seal(2);
		cyc(8);
		check("two pulses", obs[S_BATT], 1'b1);
		i_svrmc_proc_model.seal(1);
		waitFor(S_BATT, 1'b0, 8, n);
		check("sealed", inr(n, 0, 8), 1'b1);
		{bat, trip} = 2'h0;
		cyc(8);
		check("still sealed", obs[S_BATT], 1'b0);
		bat = 1'b1;
		waitFor(S_BATT, 1'b1, 8, n);
		check("seal cleared", inr(n, 0, 8), 1'b1);
	endtask

	task automatic tBacked();
		int n, s, w;
		doReset(1'b1);
		sense = 1'b1;
		cyc(2 * T);
		check("rst off low", obs[S_RST:S_RSTN], 2'h1);
		{bat, trip} = 2'h3;
		waitFor(S_RST, 1'b1, 6, n);
		check("rst at bat", inr(n, 0, 6), 1'b1);
		waitFor(S_RST, 1'b0, HHI, n);
		check("backed hold", inr(n, HLO - 6, HHI), 1'b1);
		sense = 1'b0;
		pulse(s, w);
		check("backed width", inr(w, WLO, WHI), 1'b1);
		waitFor(S_WARN, 1'b0, 8 * T, n);
		check("silent", n, -1);
		check("silent rst", obs[S_RST], 1'b0);
		i_svrmc_proc_model.strobe();
		waitFor(S_WARN, 1'b0, 8, n);
		check("strobe warn", inr(n, 0, 8), 1'b1);
		waitFor(S_WARN, 1'b1, WHI, n);
		check("strobe width", inr(n, WLO, WHI), 1'b1);
		sense = 1'b1;
		waitFor(S_RST, 1'b1, 8, n);
		check("restart", inr(n, 0, 8), 1'b1);
		waitFor(S_RST, 1'b0, HHI, n);
		check("restart hold", inr(n, HLO - 6, HHI), 1'b1);
		trip = 1'b0;
		waitFor(S_RST, 1'b1, 4 * T, n);
		check("no rst at trip", n, -1);
		bat = 1'b0;
		cyc(6);
		check("battery held", obs[S_RSTN:S_OE], 3'h7);
		check("fail backed", obs[S_FAIL], 1'b1);
		{bat, trip} = 2'h3;
		waitFor(S_RST, 1'b1, 6, n);
		check("rst at bat again", inr(n, 0, 6), 1'b1);
		sense = 1'b0;
		waitFor(S_WARN, 1'b0, HHI, n);
		cyc(2);
		check("warn swaps rst", obs[S_RST:S_RSTN], 2'h1);
		check("swap in hold", inr(n, 0, HLO), 1'b1);
	endtask

	////////////////////////////////////////
	initial begin
		arst_n = 1'b0;
		{bat, trip, sense, mode} = 4'h0;
		failCount = 0;
		checkCount = 0;
		tVolUp();
		tFilter();
		tVolDown();
		tSeal();
		tBacked();
		stopTest();
	end

	// the whole run needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		failCount++;
		stopTest();
	end
endmodule
